/* File: rtl/ovc_regs.svh */
// Octet codes and field constants of the variable container codec
`ifndef OVC_REGS_SVH
`define OVC_REGS_SVH
`define OVC_BR_END 8'h00
`define OVC_BR_MAX 8'h07
`define OVC_WID_IND_BIT 7
`define OVC_LEN_FULL 8'h80
`define OVC_IND_OVERSIZE 7'h01
`define OVC_IND_ATTR_ERR 7'h20
`define OVC_IND_ATTR_LAST 7'h24
`define OVC_IND_OBJ_END 7'h40
`define OVC_IND_OBJ_LAST 7'h44
`define OVC_IND_PKG_END 7'h60
`define OVC_IND_PKG_LAST 7'h64
`define OVC_SEL_WIDTH 8'h02
`define OVC_SEL_BRANCH 8'h07
`define OVC_SEL_LEAF 16'h014A
`endif

/* File: rtl/ovc_pkg.sv */
// Types of the variable container codec
package ovc_pkg;
   typedef enum logic [2:0] {P_BR, P_LFH, P_LFL, P_WID, P_VAL, P_SKIP} ovc_pst_e;
   typedef enum logic [2:0] {E_IDLE, E_BR, E_LFH, E_LFL, E_WID, E_VAL} ovc_est_e;
   typedef enum logic [1:0] {K_HDR, K_ATTR, K_IND, K_SEL} ovc_kind_e;
endpackage

/* File: rtl/ovc_codec.sv */
// Variable descriptor parser and variable container encoder
`timescale 1ns/1ps
`default_nettype none
`include "ovc_regs.svh"
module ovc_codec (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic nrst_in,
   // Request data field in
   input wire logic rx_valid_in,
   input wire logic rx_first_in,
   input wire logic [7:0] rx_data_in,
   input wire logic [10:0] rx_flen_in,
   // Parsed descriptors out
   output logic desc_valid_out,
   output logic [7:0] desc_branch_out,
   output logic [15:0] desc_leaf_out,
   output logic inst_valid_out,
   output logic [15:0] inst_out,
   output logic grp_end_out,
   // Container commands in
   input wire logic enc_valid_in,
   output logic enc_ready_out,
   input wire logic [1:0] enc_kind_in,
   input wire logic [7:0] enc_branch_in,
   input wire logic [15:0] enc_leaf_in,
   input wire logic [7:0] enc_len_in,
   input wire logic [6:0] enc_ind_in,
   input wire logic [10:0] tx_room_in,
   // Attribute value octets in
   input wire logic val_valid_in,
   output logic val_ready_out,
   input wire logic [7:0] val_data_in,
   // Response octets out
   output logic tx_valid_out,
   output logic [7:0] tx_data_out,
   input wire logic tx_ready_in
);
   // ==========================================================
   // Parser
   ovc_pkg::ovc_pst_e p_st_r;
   logic [7:0] br_r;
   logic [7:0] lfh_r;
   logic [10:0] rem_r;
   logic [7:0] pcnt_r;
   logic sel_ok_r;
   logic [7:0] ihi_r;
   wire [10:0] rem_now = rx_first_in ? rx_flen_in - 11'h001 : rem_r - 11'h001;
   wire ovc_pkg::ovc_pst_e p_cur = rx_first_in ? ovc_pkg::P_BR : p_st_r;
   wire [7:0] wlen = (rx_data_in[6:0] == 7'h00) ? `OVC_LEN_FULL : {1'b0, rx_data_in[6:0]};
   wire is_ind = rx_data_in[`OVC_WID_IND_BIT];
   wire is_sel = (br_r == `OVC_SEL_BRANCH) && ({lfh_r, rx_data_in} == `OVC_SEL_LEAF);
   wire br_known = br_r <= `OVC_BR_MAX;
   wire overrun = {3'h0, wlen} > rem_now;
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         p_st_r <= ovc_pkg::P_BR;
         br_r <= 8'h00;
         lfh_r <= 8'h00;
         rem_r <= 11'h000;
         pcnt_r <= 8'h00;
         sel_ok_r <= 1'b0;
         ihi_r <= 8'h00;
         desc_valid_out <= 1'b0;
         desc_branch_out <= 8'h00;
         desc_leaf_out <= 16'h0000;
         inst_valid_out <= 1'b0;
         inst_out <= 16'h0000;
         grp_end_out <= 1'b0;
      end else begin
         desc_valid_out <= 1'b0;
         grp_end_out <= 1'b0;
         if (rx_valid_in) begin
            rem_r <= rem_now;
            if (rx_first_in) begin
               inst_valid_out <= 1'b0;
            end
            unique case (p_cur)
               ovc_pkg::P_BR: begin
                  br_r <= rx_data_in;
                  p_st_r <= (rx_data_in == `OVC_BR_END) ? ovc_pkg::P_SKIP
                     : ovc_pkg::P_LFH;
               end
               ovc_pkg::P_LFH: begin
                  lfh_r <= rx_data_in;
                  p_st_r <= ovc_pkg::P_LFL;
               end
               ovc_pkg::P_LFL: begin
                  p_st_r <= is_sel ? ovc_pkg::P_WID : ovc_pkg::P_BR;
                  // Unknown branches dropped quietly
                  desc_valid_out <= !is_sel && br_known;
                  desc_branch_out <= br_r;
                  desc_leaf_out <= {lfh_r, rx_data_in};
               end
               ovc_pkg::P_WID: begin
                  if (is_ind) begin
                     // Reserved codes fall through with no effect
                     grp_end_out <= rx_data_in[6:0] == `OVC_IND_OBJ_END
                        || rx_data_in[6:0] == `OVC_IND_PKG_END;
                     p_st_r <= ovc_pkg::P_BR;
                  end else if (overrun) begin
                     p_st_r <= ovc_pkg::P_SKIP;
                  end else begin
                     pcnt_r <= wlen;
                     sel_ok_r <= wlen == `OVC_SEL_WIDTH;
                     p_st_r <= ovc_pkg::P_VAL;
                  end
               end
               ovc_pkg::P_VAL: begin
                  ihi_r <= rx_data_in;
                  pcnt_r <= pcnt_r - 8'h01;
                  if (pcnt_r == 8'h01) begin
                     p_st_r <= ovc_pkg::P_BR;
                     if (sel_ok_r) begin
                        inst_valid_out <= 1'b1;
                        inst_out <= {ihi_r, rx_data_in};
                     end
                  end
               end
               ovc_pkg::P_SKIP: p_st_r <= ovc_pkg::P_SKIP;
            endcase
         end
      end
   end
   // ==========================================================
   // Two-entry output buffer
   logic [7:0] b0_r;
   logic [7:0] b1_r;
   logic [1:0] bcnt_r;
   logic push;
   logic [7:0] push_data;
   wire buf_rdy = bcnt_r != 2'd2;
   wire pop = tx_valid_out && tx_ready_in;
   assign tx_valid_out = bcnt_r != 2'd0;
   assign tx_data_out = b0_r;
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         b0_r <= 8'h00;
         b1_r <= 8'h00;
         bcnt_r <= 2'd0;
      end else begin
         bcnt_r <= bcnt_r + {1'b0, push} - {1'b0, pop};
         if (pop) begin
            b0_r <= (bcnt_r == 2'd2) ? b1_r : push_data;
         end else if (push && bcnt_r == 2'd0) begin
            b0_r <= push_data;
         end
         if (push && (bcnt_r == 2'd2 || (bcnt_r == 2'd1 && !pop))) begin
            b1_r <= push_data;
         end
      end
   end
   // ==========================================================
   // Encoder
   ovc_pkg::ovc_est_e e_st_r;
   ovc_pkg::ovc_kind_e kind_r;
   logic [7:0] ebr_r;
   logic [15:0] elf_r;
   logic [7:0] wid_r;
   logic [7:0] ecnt_r;
   logic ovf_r;
   wire ovc_pkg::ovc_kind_e kin = ovc_pkg::ovc_kind_e'(enc_kind_in);
   wire [6:0] c = enc_ind_in;
   wire ind_ok = c == `OVC_IND_OVERSIZE || (c >= `OVC_IND_ATTR_ERR && c <= `OVC_IND_ATTR_LAST)
      || (c >= `OVC_IND_OBJ_END && c <= `OVC_IND_OBJ_LAST)
      || (c >= `OVC_IND_PKG_END && c <= `OVC_IND_PKG_LAST);
   wire len_ok = enc_len_in != 8'h00 && enc_len_in <= `OVC_LEN_FULL;
   wire no_fit = {3'h0, enc_len_in} >= tx_room_in;
   wire accept = enc_valid_in && enc_ready_out;
   assign enc_ready_out = e_st_r == ovc_pkg::E_IDLE;
   assign val_ready_out = e_st_r == ovc_pkg::E_VAL && kind_r == ovc_pkg::K_ATTR && buf_rdy;
   wire val_have = kind_r == ovc_pkg::K_SEL || val_valid_in;
   assign push = buf_rdy && e_st_r != ovc_pkg::E_IDLE && (e_st_r != ovc_pkg::E_VAL || val_have);
   wire [7:0] sel_oct = (ecnt_r == 8'h02) ? inst_out[15:8] : inst_out[7:0];
   wire [7:0] val_oct = (kind_r == ovc_pkg::K_SEL) ? sel_oct : val_data_in;
   always_comb begin
      unique case (e_st_r)
         ovc_pkg::E_BR: push_data = ebr_r;
         ovc_pkg::E_LFH: push_data = elf_r[15:8];
         ovc_pkg::E_LFL: push_data = elf_r[7:0];
         ovc_pkg::E_WID: push_data = wid_r;
         ovc_pkg::E_VAL: push_data = val_oct;
         default: push_data = 8'h00;
      endcase
   end
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         e_st_r <= ovc_pkg::E_IDLE;
         kind_r <= ovc_pkg::K_HDR;
         ebr_r <= 8'h00;
         elf_r <= 16'h0000;
         wid_r <= 8'h00;
         ecnt_r <= 8'h00;
         ovf_r <= 1'b0;
      end else if (accept) begin
         kind_r <= kin;
         ebr_r <= (kin == ovc_pkg::K_SEL) ? `OVC_SEL_BRANCH : enc_branch_in;
         elf_r <= (kin == ovc_pkg::K_SEL) ? `OVC_SEL_LEAF : enc_leaf_in;
         ovf_r <= kin == ovc_pkg::K_ATTR && len_ok && no_fit;
         ecnt_r <= (kin == ovc_pkg::K_SEL) ? `OVC_SEL_WIDTH : enc_len_in;
         e_st_r <= (kin == ovc_pkg::K_HDR || kin == ovc_pkg::K_SEL) ? ovc_pkg::E_BR
            : ovc_pkg::E_WID;
         unique case (kin)
            ovc_pkg::K_SEL: wid_r <= `OVC_SEL_WIDTH;
            ovc_pkg::K_IND: wid_r <= {1'b1, ind_ok ? c : `OVC_IND_ATTR_ERR};
            ovc_pkg::K_ATTR: wid_r <= !len_ok ? {1'b1, `OVC_IND_ATTR_ERR}
               : no_fit ? {1'b1, `OVC_IND_OVERSIZE}
               : {1'b0, enc_len_in[6:0]};
            ovc_pkg::K_HDR: wid_r <= 8'h00;
         endcase
      end else if (push) begin
         unique case (e_st_r)
            ovc_pkg::E_BR: e_st_r <= ovc_pkg::E_LFH;
            ovc_pkg::E_LFH: e_st_r <= ovc_pkg::E_LFL;
            ovc_pkg::E_LFL: e_st_r <= (kind_r == ovc_pkg::K_HDR) ? ovc_pkg::E_IDLE
               : ovc_pkg::E_WID;
            ovc_pkg::E_WID: e_st_r <= wid_r[7] ? ovc_pkg::E_IDLE : ovc_pkg::E_VAL;
            ovc_pkg::E_VAL: begin
               ecnt_r <= ecnt_r - 8'h01;
               if (ecnt_r == 8'h01) begin
                  e_st_r <= ovc_pkg::E_IDLE;
               end
            end
            default: e_st_r <= ovc_pkg::E_IDLE;
         endcase
      end
   end
   // ==========================================================
   // Checks
   wire wpush = push && e_st_r == ovc_pkg::E_WID;
   // End branch parks the parser until the next frame starts
   chk_branch_end: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      (rx_valid_in && p_cur == ovc_pkg::P_BR && rx_data_in == `OVC_BR_END)
      || (p_st_r == ovc_pkg::P_SKIP && !(rx_valid_in && rx_first_in))
      |=> p_st_r == ovc_pkg::P_SKIP && !desc_valid_out)
      else $error("descriptor after end branch");
   chk_overrun_drop: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      rx_valid_in && p_cur == ovc_pkg::P_WID && !is_ind && overrun |=> p_st_r == ovc_pkg::P_SKIP)
      else $error("overrunning container kept");
   chk_sel_commit: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      rx_valid_in && !rx_first_in && p_st_r == ovc_pkg::P_VAL && pcnt_r == 8'h01 && sel_ok_r
      |=> inst_valid_out && inst_out == {$past(ihi_r), $past(rx_data_in)})
      else $error("instance not selected");
   chk_grp_end: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      rx_valid_in && p_cur == ovc_pkg::P_WID && (rx_data_in == 8'hC0 || rx_data_in == 8'hE0)
      |=> grp_end_out)
      else $error("end of object missed");
   chk_ind_no_value: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      wpush && push_data[7] |=> e_st_r == ovc_pkg::E_IDLE)
      else $error("value after indication");
   chk_len_code: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      wpush && !push_data[7] && kind_r == ovc_pkg::K_ATTR
      |-> push_data[6:0] == ecnt_r[6:0] && ecnt_r != 8'h00)
      else $error("width code mismatch");
   chk_oversize: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      wpush && ovf_r |-> push_data == {1'b1, `OVC_IND_OVERSIZE})
      else $error("oversize not flagged");
   chk_no_reserved: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      wpush && push_data[7] |-> push_data[6:0] == 7'h01
      || (push_data[6:0] >= 7'h20 && push_data[6:0] <= 7'h24)
      || (push_data[6:0] >= 7'h40 && push_data[6:0] <= 7'h44)
      || (push_data[6:0] >= 7'h60 && push_data[6:0] <= 7'h64))
      else $error("reserved indication sent");
   chk_buf_hold: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_data_out))
      else $error("stalled octet lost");
   chk_desc_known: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      desc_valid_out |-> desc_branch_out != `OVC_BR_END && desc_branch_out <= `OVC_BR_MAX)
      else $error("unknown branch reported");
   chk_sel_width: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      wpush && kind_r == ovc_pkg::K_SEL |-> push_data == `OVC_SEL_WIDTH)
      else $error("selector width wrong");
   // An oversize attribute must leave its value octets with the client
   chk_ovf_no_pull: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
      ovf_r && e_st_r != ovc_pkg::E_IDLE |-> !val_ready_out)
      else $error("value pulled after oversize");
   cov_sel: cover property (@(posedge core_clk_in) inst_valid_out && desc_valid_out);
   cov_ovf: cover property (@(posedge core_clk_in) wpush && ovf_r);
   cov_full: cover property (@(posedge core_clk_in) bcnt_r == 2'd2 && !tx_ready_in);
   cov_grp: cover property (@(posedge core_clk_in) grp_end_out);
   cov_echo: cover property (@(posedge core_clk_in) wpush && kind_r == ovc_pkg::K_SEL);
endmodule
`default_nettype wire

/* File: testbench/ovc_far_end.sv */
// Far-end client model: sinks response octets and can stall
`timescale 1ns/1ps
`default_nettype none
module ovc_far_end (
   // Clock
   input wire logic core_clk_in,
   // Stall control
   input wire logic hold_in,
   input wire logic slow_in,
   // Response octets
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_data_in,
   output logic tx_ready_out
);
   logic ph = 1'b0;
   logic rdy_r = 1'b0;
   logic [7:0] got_q[$];
   assign tx_ready_out = rdy_r;
   // ==========
   // Ready moves on the falling edge only, slow mode halves the rate
   always @(negedge core_clk_in) begin
      ph <= ~ph;
      rdy_r <= ~hold_in & ~(slow_in & ph);
   end
   // Octets kept in arrival order, most significant first
   always @(posedge core_clk_in) begin
      if (tx_valid_in && tx_ready_out) begin
         got_q.push_back(tx_data_in);
      end
   end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the variable container codec
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct {
      logic [1:0] kind;
      logic [7:0] br;
      logic [15:0] lf;
      logic [7:0] len;
      logic [6:0] ind;
      logic [10:0] room;
      logic [7:0] h0;
      int nv;
   } ovc_row_s;
   logic core_clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic rx_valid_in = 1'b0;
   logic rx_first_in = 1'b0;
   logic [7:0] rx_data_in = 8'h00;
   logic [10:0] rx_flen_in = 11'h000;
   logic enc_valid_in = 1'b0;
   logic [1:0] enc_kind_in = 2'h0;
   logic [7:0] enc_branch_in = 8'h00;
   logic [15:0] enc_leaf_in = 16'h0000;
   logic [7:0] enc_len_in = 8'h00;
   logic [6:0] enc_ind_in = 7'h00;
   logic [10:0] tx_room_in = 11'h000;
   logic [7:0] val_data_in = 8'h00;
   logic hold = 1'b0;
   logic slow = 1'b0;
   logic val_on = 1'b0;
   logic desc_valid_out, inst_valid_out, grp_end_out, enc_ready_out, val_ready_out;
   logic tx_valid_out, tx_ready_in;
   logic [7:0] desc_branch_out, tx_data_out;
   logic [15:0] desc_leaf_out, inst_out;
   int mismatches = 0, num_checks = 0, rd_ptr = 0, val_cnt = 0, desc_cnt = 0, grp_cnt = 0;
   int base, d0;
   ovc_row_s rows[19] = '{
      '{2'h0, 8'h04, 16'h0001, 8'h00, 7'h00, 11'h064, 8'h04, 0},
      '{2'h1, 8'h00, 16'h0000, 8'h02, 7'h00, 11'h064, 8'h02, 2},
      '{2'h1, 8'h00, 16'h0000, 8'h04, 7'h00, 11'h005, 8'h04, 4},
      '{2'h1, 8'h00, 16'h0000, 8'h05, 7'h00, 11'h005, 8'h81, 0},
      '{2'h1, 8'h00, 16'h0000, 8'h00, 7'h00, 11'h064, 8'hA0, 0},
      '{2'h1, 8'h00, 16'h0000, 8'h81, 7'h00, 11'h200, 8'hA0, 0},
      '{2'h2, 8'h00, 16'h0000, 8'h00, 7'h01, 11'h064, 8'h81, 0},
      '{2'h2, 8'h00, 16'h0000, 8'h00, 7'h00, 11'h064, 8'hA0, 0},
      '{2'h2, 8'h00, 16'h0000, 8'h00, 7'h02, 11'h064, 8'hA0, 0},
      '{2'h2, 8'h00, 16'h0000, 8'h00, 7'h20, 11'h064, 8'hA0, 0},
      '{2'h2, 8'h00, 16'h0000, 8'h00, 7'h24, 11'h064, 8'hA4, 0},
      '{2'h2, 8'h00, 16'h0000, 8'h00, 7'h25, 11'h064, 8'hA0, 0},
      '{2'h2, 8'h00, 16'h0000, 8'h00, 7'h40, 11'h064, 8'hC0, 0},
      '{2'h2, 8'h00, 16'h0000, 8'h00, 7'h41, 11'h064, 8'hC1, 0},
      '{2'h2, 8'h00, 16'h0000, 8'h00, 7'h44, 11'h064, 8'hC4, 0},
      '{2'h2, 8'h00, 16'h0000, 8'h00, 7'h45, 11'h064, 8'hA0, 0},
      '{2'h2, 8'h00, 16'h0000, 8'h00, 7'h61, 11'h064, 8'hE1, 0},
      '{2'h2, 8'h00, 16'h0000, 8'h00, 7'h64, 11'h064, 8'hE4, 0},
      '{2'h2, 8'h00, 16'h0000, 8'h00, 7'h65, 11'h064, 8'hA0, 0}};
   logic [7:0] echo[6] = '{8'h07, 8'h01, 8'h4A, 8'h02, 8'h12, 8'h34};
   // ==========
   // Design, far end, clock and pulse counters
   ovc_codec uut (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .rx_valid_in(rx_valid_in),
      .rx_first_in(rx_first_in), .rx_data_in(rx_data_in), .rx_flen_in(rx_flen_in),
      .desc_valid_out(desc_valid_out), .desc_branch_out(desc_branch_out),
      .desc_leaf_out(desc_leaf_out), .inst_valid_out(inst_valid_out), .inst_out(inst_out),
      .grp_end_out(grp_end_out), .enc_valid_in(enc_valid_in), .enc_ready_out(enc_ready_out),
      .enc_kind_in(enc_kind_in), .enc_branch_in(enc_branch_in), .enc_leaf_in(enc_leaf_in),
      .enc_len_in(enc_len_in), .enc_ind_in(enc_ind_in), .tx_room_in(tx_room_in),
      .val_valid_in(val_on), .val_ready_out(val_ready_out), .val_data_in(val_data_in),
      .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in));
   ovc_far_end u_far (.core_clk_in(core_clk_in), .hold_in(hold), .slow_in(slow),
      .tx_valid_in(tx_valid_out), .tx_data_in(tx_data_out), .tx_ready_out(tx_ready_in));
   initial forever #50 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in) begin
      if (val_on && val_ready_out) val_cnt <= val_cnt + 1;
      if (desc_valid_out === 1'b1) desc_cnt <= desc_cnt + 1;
      if (grp_end_out === 1'b1) grp_cnt <= grp_cnt + 1;
   end
   always @(negedge core_clk_in) val_data_in <= val_cnt[7:0];
   // ==========
   // Tasks
   task automatic complete_run;
      if (mismatches == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic send_cmd(input ovc_row_s r);
      int n = 0;
      @(negedge core_clk_in);
      enc_valid_in = 1'b1;
      enc_kind_in = r.kind;
      enc_branch_in = r.br;
      enc_leaf_in = r.lf;
      enc_len_in = r.len;
      enc_ind_in = r.ind;
      tx_room_in = r.room;
      while (enc_ready_out !== 1'b1 && n < 400) begin
         @(negedge core_clk_in);
         n++;
      end
      if (enc_ready_out !== 1'b1) begin
         mismatches++;
         complete_run();
      end
      @(negedge core_clk_in);
      enc_valid_in = 1'b0;
   endtask
   task automatic expect_oct(input logic [7:0] exp);
      int n = 0;
      while (u_far.got_q.size() <= rd_ptr && n < 400) begin
         @(negedge core_clk_in);
         n++;
      end
      if (u_far.got_q.size() <= rd_ptr) begin
         mismatches++;
         complete_run();
      end
      chk("tx octet", {8'h00, exp}, {8'h00, u_far.got_q[rd_ptr]});
      rd_ptr++;
   endtask
   task automatic send_frame(input logic [7:0] f[$], input int flen);
      foreach (f[k]) begin
         @(negedge core_clk_in);
         rx_valid_in = 1'b1;
         rx_first_in = (k == 0);
         rx_data_in = f[k];
         rx_flen_in = 11'(flen);
      end
      @(negedge core_clk_in);
      rx_valid_in = 1'b0;
      rx_first_in = 1'b0;
      repeat (3) @(negedge core_clk_in);
   endtask
   // ==========
   // Main sequence
   initial begin
      repeat (3) @(negedge core_clk_in);
      chk("reset flags", 16'h0008,
         {12'h000, enc_ready_out, tx_valid_out, desc_valid_out, inst_valid_out});
      @(negedge core_clk_in);
      nrst_in = 1'b1;
      val_on = 1'b1;
      foreach (rows[i]) begin
         base = val_cnt;
         send_cmd(rows[i]);
         expect_oct(rows[i].h0);
         if (rows[i].kind == 2'h0) begin
            expect_oct(rows[i].lf[15:8]);
            expect_oct(rows[i].lf[7:0]);
         end
         for (int k = 0; k < rows[i].nv; k++) expect_oct(8'(base + k));
      end
      send_frame('{8'h07, 8'h00, 8'h02}, 3);
      chk("descriptor", 16'h0007, {8'h00, desc_branch_out});
      chk("leaf", 16'h0002, desc_leaf_out);
      d0 = desc_cnt;
      send_frame('{8'h07, 8'h01, 8'h4A, 8'h02, 8'h12, 8'h34, 8'h07, 8'h00, 8'h05, 8'h00,
                   8'h07, 8'h00, 8'h02}, 13);
      chk("desc count", 16'h0001, 16'(desc_cnt - d0));
      chk("leaf after selector", 16'h0005, desc_leaf_out);
      chk("instance valid", 16'h0001, {15'h0000, inst_valid_out});
      chk("instance", 16'h1234, inst_out);
      send_cmd('{2'h3, 8'h00, 16'h0000, 8'h00, 7'h00, 11'h064, 8'h00, 0});
      foreach (echo[k]) expect_oct(echo[k]);
      d0 = desc_cnt;
      send_frame('{8'h09, 8'h00, 8'h01, 8'h00}, 4);
      chk("unknown branch", 16'h0000, 16'(desc_cnt - d0));
      send_frame('{8'h07, 8'h01, 8'h4A, 8'h02, 8'h12, 8'h34}, 5);
      chk("overrun selector", 16'h0000, {15'h0000, inst_valid_out});
      d0 = grp_cnt;
      // Width octets reach the parser only inside a selector container
      send_frame('{8'h07, 8'h01, 8'h4A, 8'hC0, 8'h07, 8'h01, 8'h4A, 8'hE0, 8'h07, 8'h01,
                   8'h4A, 8'hA5, 8'h00}, 13);
      chk("group ends", 16'h0002, 16'(grp_cnt - d0));
      hold = 1'b1;
      send_cmd('{2'h0, 8'h03, 16'h0002, 8'h00, 7'h00, 11'h064, 8'h03, 0});
      repeat (10) @(negedge core_clk_in);
      chk("buffer full", 16'h0002, {14'h0000, tx_valid_out, enc_ready_out});
      hold = 1'b0;
      slow = 1'b1;
      expect_oct(8'h03);
      expect_oct(8'h00);
      expect_oct(8'h02);
      base = val_cnt;
      send_cmd('{2'h1, 8'h00, 16'h0000, 8'h80, 7'h00, 11'h200, 8'h00, 0});
      expect_oct(8'h00);
      for (int k = 0; k < 128; k++) expect_oct(8'(base + k));
      // Value source goes quiet: encoder must wait, not invent octets
      val_on = 1'b0;
      base = val_cnt;
      send_cmd('{2'h1, 8'h00, 16'h0000, 8'h02, 7'h00, 11'h064, 8'h00, 0});
      expect_oct(8'h02);
      repeat (6) @(negedge core_clk_in);
      chk("stalled value", 16'(rd_ptr), 16'(u_far.got_q.size()));
      val_on = 1'b1;
      expect_oct(8'(base));
      expect_oct(8'(base + 1));
      // Reset in mid-run with a header stuck in the buffer
      hold = 1'b1;
      send_cmd('{2'h0, 8'h04, 16'h0002, 8'h00, 7'h00, 11'h064, 8'h04, 0});
      repeat (4) @(negedge core_clk_in);
      nrst_in = 1'b0;
      @(negedge core_clk_in);
      chk("reset mid run", 16'h0008,
         {12'h000, enc_ready_out, tx_valid_out, desc_valid_out, inst_valid_out});
      nrst_in = 1'b1;
      hold = 1'b0;
      send_cmd('{2'h0, 8'h03, 16'h0001, 8'h00, 7'h00, 11'h064, 8'h03, 0});
      expect_oct(8'h03);
      expect_oct(8'h00);
      expect_oct(8'h01);
      repeat (10) @(negedge core_clk_in);
      chk("octet total", 16'(rd_ptr), 16'(u_far.got_q.size()));
      complete_run();
   end
endmodule
`default_nettype wire
